// file: shared/pmmc_pkg.sv
package pmmc_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned REG_W         = 16;

    // Register indices; byte address is four times the index
    localparam logic [4:0]  IDX_BASIC_CTRL   = 5'h00;
    localparam logic [4:0]  IDX_MODE_CTRL    = 5'h17;
    localparam logic [4:0]  IDX_MEDIA_STATUS = 5'h1d;
    localparam logic [4:0]  IDX_GLOBAL_CFG   = 5'h1e;

    // Field positions
    localparam int unsigned BIT_SOFT_RESET   = 15;
    localparam int unsigned RSVD_HI_LSB      = 14;
    localparam int unsigned PEND_LSB         = 8;
    localparam int unsigned PEND_W           = 6;
    localparam int unsigned BIT_MAC_IF       = 12;
    localparam int unsigned BIT_AMS_PREF     = 11;
    localparam int unsigned MEDIA_MODE_LSB   = 8;
    localparam int unsigned OVERRIDE_LSB     = 6;
    localparam int unsigned BIT_FAR_LOOP     = 3;
    localparam int unsigned GCFG_LSB         = 14;

    // Reset values
    localparam logic [1:0]  RSVD_HI_RST      = 2'h0;
    localparam logic [5:0]  PEND_RST         = 6'h00;
    localparam logic [1:0]  OVERRIDE_RST     = 2'h0;
    localparam logic        FAR_LOOP_RST     = 1'b0;
    localparam logic [1:0]  GCFG_RST         = 2'h0;

    // Media mode codes
    localparam logic [2:0]  MODE_COPPER      = 3'h0;
    localparam logic [2:0]  MODE_PROTO_XFER  = 3'h1;
    localparam logic [2:0]  MODE_1000X       = 3'h2;
    localparam logic [2:0]  MODE_100FX       = 3'h3;
    localparam logic [2:0]  MODE_RESERVED    = 3'h4;
    localparam logic [2:0]  MODE_AMS_XFER    = 3'h5;
    localparam logic [2:0]  MODE_AMS_1000X   = 3'h6;
    localparam logic [2:0]  MODE_AMS_100FX   = 3'h7;

    // Override codes
    localparam logic [1:0]  OVR_NORMAL       = 2'h0;
    localparam logic [1:0]  OVR_SERIAL       = 2'h1;
    localparam logic [1:0]  OVR_COPPER       = 2'h2;

    // Global field value that lets the interface select take effect
    localparam logic [1:0]  GCFG_MAC_VALID   = 2'h0;

    typedef enum logic [1:0] {
        SRST_IDLE,
        SRST_APPLY,
        SRST_DONE
    } pmmc_srst_t;

endpackage

// file: core/pmmc_mode_store.sv
`timescale 1ns/1ps
module pmmc_mode_store
    import pmmc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              wr_en,
    input  wire logic [PEND_W-1:0] wr_data,
    input  wire logic              commit,
    output logic      [PEND_W-1:0] pending,
    output logic      [PEND_W-1:0] active
);

    // Super-sticky: only the hardware reset clears either copy
    for (genvar i = 0; i < PEND_W; i++) begin : g_bit
        logic pend_q;
        logic act_q;

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pend_q <= PEND_RST[i];
            end else if (wr_en) begin
                pend_q <= wr_data[i];
            end
        end

        // A write in the commit cycle lands in pending only
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                act_q <= PEND_RST[i];
            end else if (commit) begin
                act_q <= pend_q;
            end
        end

        assign pending[i] = pend_q;
        assign active[i]  = act_q;
    end

endmodule

// file: core/pmmc_media_resolve.sv
`timescale 1ns/1ps
module pmmc_media_resolve
    import pmmc_pkg::*;
(
    input  wire logic [2:0] media_mode,
    input  wire logic       prefer_copper,
    input  wire logic       mac_1000x_sel,
    input  wire logic [1:0] override_sel,
    input  wire logic [1:0] global_cfg,
    input  wire logic       copper_link,
    input  wire logic       serial_link,
    output logic            mac_1000x,
    output logic            copper_en,
    output logic            serial_en,
    output logic            proto_xfer,
    output logic            fiber_1000x,
    output logic            fiber_100fx,
    output logic            ams_en,
    output logic            mode_invalid
);

    logic want_copper;

    always_comb begin
        mac_1000x    = mac_1000x_sel && (global_cfg == GCFG_MAC_VALID);
        mode_invalid = (media_mode == MODE_RESERVED);
        ams_en       = media_mode[2] && !mode_invalid;
        proto_xfer   = 1'b0;
        fiber_1000x  = 1'b0;
        fiber_100fx  = 1'b0;
        want_copper  = 1'b0;
        copper_en    = 1'b0;
        serial_en    = 1'b0;
        case (media_mode[1:0])
            2'h1: proto_xfer  = !mode_invalid;
            2'h2: fiber_1000x = 1'b1;
            2'h3: fiber_100fx = 1'b1;
            default: ;
        endcase
        if (ams_en) begin
            // Preferred medium wins while up, else whichever is up
            if (prefer_copper) begin
                want_copper = copper_link || !serial_link;
            end else begin
                want_copper = copper_link && !serial_link;
            end
            if (override_sel == OVR_SERIAL) begin
                want_copper = 1'b0;
            end else if (override_sel == OVR_COPPER) begin
                want_copper = 1'b1;
            end
            copper_en = want_copper;
            serial_en = !want_copper;
        end else if (media_mode == MODE_COPPER) begin
            copper_en = 1'b1;
        end else if (!mode_invalid) begin
            serial_en = 1'b1;
        end
    end

endmodule

// file: core/pmmc_top.sv
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
// Operation
// R1: Bit 12 picks serial-gigabit or 1000X interface
// R2: Interface pick valid only when global field 00
// R3: Bit 11 picks preferred medium, default serial
// R4: Codes 000-011 select one fixed medium
// R5: Codes 101-111 auto-sense copper versus serial; 100 reserved
// R6: Bits 7:6 force auto-sense to one medium
// R7: Bit 3 enables far-end loopback
// R8: Bits 13:8 take effect at software reset
// R9: Bits 13:8 read back the active mode
// R10: Super-sticky fields survive software reset
// R11: Reserved read-only bits read zero; mode bits 15:14 are writable here and read back the written value
module pmmc_top
    import pmmc_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              RESET_N,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [DATA_W-1:0] PWDATA,
    input  wire logic [3:0]        PSTRB,
    output logic      [DATA_W-1:0] PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              COPPER_LINK_UP,
    input  wire logic              SERIAL_LINK_UP,
    output logic                   MAC_IF_1000X,
    output logic                   COPPER_MEDIA_EN,
    output logic                   SERIAL_MEDIA_EN,
    output logic                   SERIAL_PROTO_XFER,
    output logic                   FIBER_1000X_ANEG,
    output logic                   FIBER_100FX,
    output logic                   AUTO_MEDIA_SELECT_EN,
    output logic                   FAR_END_LOOPBACK,
    output logic                   SOFT_RESET_ACTIVE
);

    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] prdata_d;
    logic              pready_q;
    logic              pslverr_q;
    logic              pslverr_d;
    logic              access;
    logic              wr_commit;
    logic              addr_ok;
    logic [4:0]        idx;
    logic              hit_basic;
    logic              hit_mode;
    logic              hit_status;
    logic              hit_gcfg;
    logic [REG_W-1:0]  old_word;
    logic [REG_W-1:0]  wr_word;

    pmmc_srst_t        srst_q;
    logic              srst_start;
    logic              srst_active_q;
    logic              commit;
    logic [1:0]        rsvd_hi_q;
    logic [1:0]        override_q;
    logic              far_loop_q;
    logic [1:0]        gcfg_q;
    logic [PEND_W-1:0] pending;
    logic [PEND_W-1:0] active;
    logic [REG_W-1:0]  mode_word;
    logic [REG_W-1:0]  status_word;

    logic              r_mac;
    logic              r_copper;
    logic              r_serial;
    logic              r_xfer;
    logic              r_1000x;
    logic              r_100fx;
    logic              r_ams;
    logic              r_invalid;

    logic              mac_q;
    logic              copper_q;
    logic              serial_q;
    logic              xfer_q;
    logic              fib1000_q;
    logic              fib100_q;
    logic              ams_q;
    logic              invalid_q;

    // Address decode: word aligned, inside the register window
    assign idx        = PADDR[6:2];
    assign addr_ok    = (PADDR[1:0] == 2'h0) && (PADDR[ADDR_W-1:7] == '0);
    assign hit_basic  = addr_ok && (idx == IDX_BASIC_CTRL);
    assign hit_mode   = addr_ok && (idx == IDX_MODE_CTRL);
    assign hit_status = addr_ok && (idx == IDX_MEDIA_STATUS);
    assign hit_gcfg   = addr_ok && (idx == IDX_GLOBAL_CFG);

    // One wait state: data is prepared first, write lands on the ready edge
    assign access    = PSEL && PENABLE && !pready_q;
    assign wr_commit = PSEL && PENABLE && pready_q && PWRITE && !pslverr_q;

    // Active copy read back, never the pending one
    assign mode_word = {rsvd_hi_q[1], rsvd_hi_q[0], active,              // [R9]
                        override_q, 2'h0, far_loop_q, 3'h0};             // [R11]

    assign status_word = {8'h00, (pending != active), invalid_q, ams_q, mac_q,
                          fib100_q, fib1000_q, serial_q, copper_q};

    always_comb begin
        old_word = '0;
        if (hit_mode) begin
            old_word = {rsvd_hi_q, pending, override_q, 2'h0, far_loop_q, 3'h0};
        end else if (hit_gcfg) begin
            old_word = {gcfg_q, 14'h0000};
        end
    end

    // Byte lanes merge over the stored word
    always_comb begin
        wr_word[7:0]  = PSTRB[0] ? PWDATA[7:0]  : old_word[7:0];
        wr_word[15:8] = PSTRB[1] ? PWDATA[15:8] : old_word[15:8];
    end

    always_comb begin
        prdata_d  = '0;
        pslverr_d = 1'b0;
        if (hit_basic) begin
            prdata_d[BIT_SOFT_RESET] = (srst_q != SRST_IDLE);
        end else if (hit_mode) begin
            prdata_d[REG_W-1:0] = mode_word;
        end else if (hit_status) begin
            prdata_d[REG_W-1:0] = status_word;
        end else if (hit_gcfg) begin
            prdata_d[REG_W-1:0] = {gcfg_q, 14'h0000};
        end else begin
            pslverr_d = 1'b1;
        end
        if (PWRITE) begin
            prdata_d = '0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pready_q <= 1'b0;
        end else if (access) begin
            pready_q <= 1'b1;
        end else begin
            pready_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pslverr_q <= 1'b0;
        end else if (access) begin
            pslverr_q <= pslverr_d;
        end else begin
            pslverr_q <= 1'b0;
        end
    end

    // Read data stands only in the ready cycle, zero otherwise
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prdata_q <= '0;
        end else if (access) begin
            prdata_q <= prdata_d;
        end else begin
            prdata_q <= '0;
        end
    end

    // Software reset sequencer; bit reads 1 until one cycle after the commit
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            srst_q <= SRST_IDLE;
        end else begin
            case (srst_q)
                SRST_IDLE: begin
                    if (srst_start) begin
                        srst_q <= SRST_APPLY;                           // [R8]
                    end
                end
                SRST_APPLY: srst_q <= SRST_DONE;
                SRST_DONE:  srst_q <= SRST_IDLE;
                default:    srst_q <= SRST_IDLE;
            endcase
        end
    end

    assign srst_start = wr_commit && hit_basic && PSTRB[1] && PWDATA[BIT_SOFT_RESET];
    assign commit     = (srst_q == SRST_APPLY);

    // Own flop so the status pin never shows a state decode glitch
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            srst_active_q <= 1'b0;
        end else if (srst_q == SRST_IDLE) begin
            srst_active_q <= srst_start;                                // [R8]
        end else begin
            srst_active_q <= (srst_q == SRST_APPLY);
        end
    end

    // Pending fields move to active only on commit
    pmmc_mode_store u_store (
        .clk     (CLK),
        .rst_n   (RESET_N),
        .wr_en   (wr_commit && hit_mode),
        .wr_data (wr_word[PEND_LSB +: PEND_W]),
        .commit  (commit),                                              // [R8]
        .pending (pending),
        .active  (active)                                               // [R10]
    );

    // Plain fields return to defaults on software reset; a write in the commit cycle is dropped
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            override_q <= OVERRIDE_RST;
            rsvd_hi_q  <= RSVD_HI_RST;
        end else if (commit) begin
            override_q <= OVERRIDE_RST;
            rsvd_hi_q  <= RSVD_HI_RST;                                  // [R11]
        end else if (wr_commit && hit_mode) begin
            override_q <= wr_word[OVERRIDE_LSB +: 2];                   // [R6]
            rsvd_hi_q  <= wr_word[RSVD_HI_LSB +: 2];
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            far_loop_q <= FAR_LOOP_RST;
        end else if (commit) begin
            far_loop_q <= FAR_LOOP_RST;
        end else if (wr_commit && hit_mode) begin
            far_loop_q <= wr_word[BIT_FAR_LOOP];                        // [R7]
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            gcfg_q <= GCFG_RST;
        end else if (wr_commit && hit_gcfg) begin
            gcfg_q <= wr_word[GCFG_LSB +: 2];
        end
    end

    pmmc_media_resolve u_resolve (
        .media_mode    (active[MEDIA_MODE_LSB-PEND_LSB +: 3]),          // [R4] [R5]
        .prefer_copper (active[BIT_AMS_PREF-PEND_LSB]),                 // [R3]
        .mac_1000x_sel (active[BIT_MAC_IF-PEND_LSB]),                   // [R1]
        .override_sel  (override_q),                                    // [R6]
        .global_cfg    (gcfg_q),                                        // [R2]
        .copper_link   (COPPER_LINK_UP),
        .serial_link   (SERIAL_LINK_UP),
        .mac_1000x     (r_mac),
        .copper_en     (r_copper),
        .serial_en     (r_serial),
        .proto_xfer    (r_xfer),
        .fiber_1000x   (r_1000x),
        .fiber_100fx   (r_100fx),
        .ams_en        (r_ams),
        .mode_invalid  (r_invalid)
    );

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mac_q <= 1'b0;
        end else begin
            mac_q <= r_mac;                                             // [R1] [R2]
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            invalid_q <= 1'b0;
        end else begin
            invalid_q <= r_invalid;
        end
    end

    // Media is held off from the second software reset cycle until one cycle after it ends; auto-sense too, so
    // the flag never stands without its serial flavour
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            copper_q  <= 1'b0;
            serial_q  <= 1'b0;
            xfer_q    <= 1'b0;
            fib1000_q <= 1'b0;
            fib100_q  <= 1'b0;
            ams_q     <= 1'b0;
        end else if (srst_q != SRST_IDLE) begin
            copper_q  <= 1'b0;
            serial_q  <= 1'b0;
            xfer_q    <= 1'b0;
            fib1000_q <= 1'b0;
            fib100_q  <= 1'b0;
            ams_q     <= 1'b0;
        end else begin
            copper_q  <= r_copper;                                      // [R5]
            serial_q  <= r_serial;
            xfer_q    <= r_xfer;                                        // [R4]
            fib1000_q <= r_1000x;
            fib100_q  <= r_100fx;
            ams_q     <= r_ams;
        end
    end

    assign PRDATA               = prdata_q;
    assign PREADY               = pready_q;
    assign PSLVERR              = pslverr_q;
    assign MAC_IF_1000X         = mac_q;
    assign COPPER_MEDIA_EN      = copper_q;
    assign SERIAL_MEDIA_EN      = serial_q;
    assign SERIAL_PROTO_XFER    = xfer_q;
    assign FIBER_1000X_ANEG     = fib1000_q;
    assign FIBER_100FX          = fib100_q;
    assign AUTO_MEDIA_SELECT_EN = ams_q;
    assign FAR_END_LOOPBACK     = far_loop_q;                           // [R7]
    assign SOFT_RESET_ACTIVE    = srst_active_q;

endmodule

// file: tb/pmmc_top_asserts.sv
`timescale 1ns/1ps
module pmmc_top_asserts
    import pmmc_pkg::*;
(
    input wire logic              CLK,
    input wire logic              RESET_N,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [DATA_W-1:0] PWDATA,
    input wire logic [3:0]        PSTRB,
    input wire logic [DATA_W-1:0] PRDATA,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    input wire logic              COPPER_MEDIA_EN,
    input wire logic              SERIAL_MEDIA_EN,
    input wire logic              SERIAL_PROTO_XFER,
    input wire logic              FIBER_1000X_ANEG,
    input wire logic              FIBER_100FX,
    input wire logic              AUTO_MEDIA_SELECT_EN,
    input wire logic              FAR_END_LOOPBACK,
    input wire logic              SOFT_RESET_ACTIVE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    wire logic acc = PSEL && PENABLE && !PREADY;
    wire logic wr_mode = acc && PWRITE && PADDR == 12'h05c;
    wire logic [2:0] flav = {SERIAL_PROTO_XFER, FIBER_1000X_ANEG, FIBER_100FX};
    wire logic srst_req = acc && PWRITE && PADDR == 12'h000 && PSTRB[1] && PWDATA[15];

    a_ready_one_wait: assert property (acc |=> PREADY)
        else $error("ready late");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held");
    a_err_misalign: assert property (acc && PADDR[1:0] != 2'h0 |=> PSLVERR && PRDATA == 32'h0)
        else $error("misaligned not refused");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_srst_two_cycles: assert property (srst_req |=>
        ##1 SOFT_RESET_ACTIVE[*2] ##1 !SOFT_RESET_ACTIVE)
        else $error("soft reset window wrong");
    a_srst_media_off: assert property (SOFT_RESET_ACTIVE && $past(SOFT_RESET_ACTIVE)
        |-> !COPPER_MEDIA_EN && !SERIAL_MEDIA_EN)
        else $error("media on during soft reset");
    a_one_medium: assert property (!(COPPER_MEDIA_EN && SERIAL_MEDIA_EN))
        else $error("both media enabled");
    a_flavour_single: assert property ($onehot0(flav))
        else $error("several serial flavours");
    a_ams_flavour: assert property (AUTO_MEDIA_SELECT_EN && !SOFT_RESET_ACTIVE
        |-> flav != 3'h0)
        else $error("auto sense without flavour");
    a_loop_on: assert property (wr_mode && PSTRB[0] && PWDATA[3]
        |=> ##[1:2] FAR_END_LOOPBACK)
        else $error("loopback not enabled");

    c_srst: cover property (SOFT_RESET_ACTIVE);
    c_err: cover property (PSLVERR);
    c_ams_serial: cover property (AUTO_MEDIA_SELECT_EN && SERIAL_MEDIA_EN);
    c_ams_copper: cover property (AUTO_MEDIA_SELECT_EN && COPPER_MEDIA_EN);
endmodule

bind pmmc_top pmmc_top_asserts u_pmmc_top_asserts (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .COPPER_MEDIA_EN(COPPER_MEDIA_EN),
    .SERIAL_MEDIA_EN(SERIAL_MEDIA_EN), .SERIAL_PROTO_XFER(SERIAL_PROTO_XFER),
    .FIBER_1000X_ANEG(FIBER_1000X_ANEG), .FIBER_100FX(FIBER_100FX),
    .AUTO_MEDIA_SELECT_EN(AUTO_MEDIA_SELECT_EN), .FAR_END_LOOPBACK(FAR_END_LOOPBACK),
    .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE));

// file: tb/phy_media_mode_control_tb.sv
`timescale 1ns/1ps
module phy_media_mode_control_tb
    import pmmc_pkg::*;
;
    localparam logic [ADDR_W-1:0] A_BASIC = 12'h000;
    localparam logic [ADDR_W-1:0] A_MODE  = 12'h05c;
    localparam logic [ADDR_W-1:0] A_GCFG  = 12'h078;
    logic              CLK, RESET_N, PSEL, PENABLE, PWRITE, COPPER_LINK_UP, SERIAL_LINK_UP;
    logic [ADDR_W-1:0] PADDR;
    logic [DATA_W-1:0] PWDATA, PRDATA, rd;
    logic [3:0]        PSTRB;
    logic              PREADY, PSLVERR, MAC_IF_1000X, COPPER_MEDIA_EN, SERIAL_MEDIA_EN, err;
    logic              SERIAL_PROTO_XFER, FIBER_1000X_ANEG, FIBER_100FX;
    logic              AUTO_MEDIA_SELECT_EN, FAR_END_LOOPBACK, SOFT_RESET_ACTIVE;
    int                mismatches, total_checks, seed;

    pmmc_top u_pmmc_top (.CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .COPPER_LINK_UP(COPPER_LINK_UP),
        .SERIAL_LINK_UP(SERIAL_LINK_UP), .MAC_IF_1000X(MAC_IF_1000X),
        .COPPER_MEDIA_EN(COPPER_MEDIA_EN), .SERIAL_MEDIA_EN(SERIAL_MEDIA_EN),
        .SERIAL_PROTO_XFER(SERIAL_PROTO_XFER), .FIBER_1000X_ANEG(FIBER_1000X_ANEG),
        .FIBER_100FX(FIBER_100FX), .AUTO_MEDIA_SELECT_EN(AUTO_MEDIA_SELECT_EN),
        .FAR_END_LOOPBACK(FAR_END_LOOPBACK), .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE));

    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Holds the request until ready is seen at an edge, for up to 20 edges; no latency is assumed
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        PSTRB <= 4'hf;
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    function automatic logic [7:0] exp_out(input logic [5:0] act, input logic [1:0] ovr,
                                           input logic [1:0] g, input logic lp, cl, sl);
        logic [2:0] m;
        logic       c, s;
        m = act[2:0];
        c = 1'b0;
        s = 1'b0;
        if (!m[2]) begin
            c = (m == MODE_COPPER);
            s = (m != MODE_COPPER);
        end else if (m != MODE_RESERVED) begin
            if (ovr == OVR_SERIAL) s = 1'b1;
            else if (ovr == OVR_COPPER) c = 1'b1;
            else if (act[3]) begin
                c = cl || !sl;
                s = !c;
            end else begin
                s = sl || !cl;
                c = !s;
            end
        end
        return {act[4] && g == GCFG_MAC_VALID, c, s, m[1:0] == 2'h1, m[1:0] == 2'h2,
                m[1:0] == 2'h3, m[2] && m != MODE_RESERVED, lp};
    endfunction

    task automatic run_case(input int i);
        logic [31:0] d, d2;
        logic [1:0]  g;
        logic        cl, sl;
        logic [7:0]  outs;
        d = $random(seed);
        d2 = $random(seed);
        g = 2'($random(seed));
        {cl, sl} = 2'($random(seed));
        if (i < 8) d[10:8] = i[2:0];
        apb(1'b1, A_MODE, d);
        apb(1'b1, A_BASIC, 32'h8000);
        @(posedge CLK);
        chk("srst_active", {31'h0, SOFT_RESET_ACTIVE}, 32'h1);
        repeat (3) @(posedge CLK);
        apb(1'b0, A_MODE, 32'h0);
        chk("mode_commit", rd, {18'h0, d[13:8], 8'h0});
        d2[13:8] = ~d[13:8];
        apb(1'b1, A_MODE, d2);
        apb(1'b1, A_GCFG, {16'h0, g, 14'h0});
        apb(1'b0, A_MODE, 32'h0);
        chk("mode_pend", rd, {16'h0, d2[15:14], d[13:8], d2[7:6], 2'h0, d2[3], 3'h0});
        COPPER_LINK_UP <= cl;
        SERIAL_LINK_UP <= sl;
        repeat (3) @(posedge CLK);
        outs = {MAC_IF_1000X, COPPER_MEDIA_EN, SERIAL_MEDIA_EN, SERIAL_PROTO_XFER,
                FIBER_1000X_ANEG, FIBER_100FX, AUTO_MEDIA_SELECT_EN, FAR_END_LOOPBACK};
        chk("media", {24'h0, outs}, {24'h0, exp_out(d[13:8], d2[7:6], g, d2[3], cl, sl)});
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // About 800 cycles are needed; the margin covers a stuck handshake
    initial begin
        repeat (5000) @(posedge CLK);
        mismatches++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        seed = 39;
        {PSEL, PENABLE, PWRITE, COPPER_LINK_UP, SERIAL_LINK_UP, RESET_N} = 6'h00;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        PSTRB = 4'h0;
        repeat (20) @(posedge CLK);
        RESET_N <= 1'b1;
        apb(1'b0, A_MODE, 32'h0);
        chk("mode_reset", rd, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 24; i++) run_case(i);
        $display("test mode cases done");
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        apb(1'b1, A_MODE + 12'h002, 32'hffff);
        chk("misaligned_err", {31'h0, err}, 32'h1);
        $display("test refusals done");
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        apb(1'b0, A_MODE, 32'h0);
        chk("mode_hw_reset", rd, 32'h0);
        $display("test hardware reset done");
        give_verdict();
    end
endmodule
